// ===== ret_rot_pkg.sv
// Shared constants and types for the return and rotate execution block
package ret_rot_pkg;
	localparam int WORD_W   = 8;
	localparam int PC_W     = 13;
	localparam int INSN_W   = 14;
	localparam int FADDR_W  = 7;
	// Opcode patterns of the four handled instructions
	localparam logic [13:0] INTERRUPT_RETURN_OP  = 14'h0009;
	localparam logic [13:0] SUB_RETURN_OP        = 14'h0008;
	localparam logic [5:0]  RETURN_LITERAL_TOP   = 6'h0D;
	localparam logic [5:0]  ROTATE_LEFT_TOP      = 6'h0D;
	localparam logic [1:0]  RETURN_LITERAL_HI    = 2'h3;
	localparam logic [5:0]  ROTATE_LEFT_HI       = 6'h0D;
	// Field positions
	localparam int LIT_LSB     = 0;
	localparam int FADDR_LSB   = 0;
	localparam int DEST_BIT    = 7;
	localparam int OPC_LSB     = 8;
	localparam int LIT_OPC_LSB = 10;
	localparam int GIE_BIT     = 7;
	localparam int MSB_BIT     = 7;
	localparam logic DEST_W    = 1'b0;
	// Instruction cycles for each return
	localparam logic [1:0] RETURN_CYCLES = 2'h2;

	typedef enum logic [1:0] {
		ST_IDLE  = 2'b00,
		ST_FLUSH = 2'b01
	} state_type;

	typedef enum logic [2:0] {
		OP_NONE,
		OP_IRQ_RET,
		OP_LIT_RET,
		OP_SUB_RET,
		OP_ROT_LEFT
	} op_type;
endpackage

// ===== ret_rot_if.sv
// Decoded-instruction bundle between the decoder and the execute logic
`timescale 1ns/1ps
interface ret_rot_if;
	ret_rot_pkg::op_type                    op;
	logic [ret_rot_pkg::WORD_W-1:0]         literal;
	logic [ret_rot_pkg::FADDR_W-1:0]        faddr;
	logic                                   dest;
	modport dec (output op, output literal, output faddr, output dest);
	modport exe (input op, input literal, input faddr, input dest);
endinterface

// ===== ret_rot_decode.sv
// Opcode decoder for the return and rotate instructions
`timescale 1ns/1ps
module ret_rot_decode (
	input  wire logic [ret_rot_pkg::INSN_W-1:0] i_insn,
	input  wire logic                           i_valid,
	ret_rot_if.dec                              dec
);
	// Classify the opcode word
	function automatic ret_rot_pkg::op_type classify(input logic [ret_rot_pkg::INSN_W-1:0] w);
		if (w == ret_rot_pkg::INTERRUPT_RETURN_OP) begin
			return ret_rot_pkg::OP_IRQ_RET;
		end else if (w == ret_rot_pkg::SUB_RETURN_OP) begin
			return ret_rot_pkg::OP_SUB_RET;
		end else if (w[13:ret_rot_pkg::LIT_OPC_LSB] == {ret_rot_pkg::RETURN_LITERAL_HI, 2'h1}) begin
			return ret_rot_pkg::OP_LIT_RET;
		end else if (w[13:ret_rot_pkg::OPC_LSB] == ret_rot_pkg::ROTATE_LEFT_HI) begin
			return ret_rot_pkg::OP_ROT_LEFT;
		end
		return ret_rot_pkg::OP_NONE;
	endfunction

	// Fields are split unconditionally; op gates their use
	always_comb begin
		dec.op      = i_valid ? classify(i_insn) : ret_rot_pkg::OP_NONE;
		dec.literal = i_insn[ret_rot_pkg::LIT_LSB +: ret_rot_pkg::WORD_W];
		dec.faddr   = i_insn[ret_rot_pkg::FADDR_LSB +: ret_rot_pkg::FADDR_W];
		dec.dest    = i_insn[ret_rot_pkg::DEST_BIT];
	end
endmodule

// ===== return_and_rotate_exec.sv
// Execute stage for interrupt return, literal return, subroutine return and rotate left
`timescale 1ns/1ps
// Notes on behaviour
// - Interrupt return pops the stack and loads the popped top into PC.
// - Interrupt return sets global interrupt enable, bit 7; arithmetic flags untouched.
// - Interrupt return is one word and takes two instruction cycles.
// - Literal return writes its 8-bit immediate into the working register.
// - Literal return loads PC from stack top, two cycles, no flags changed.
// - Subroutine return pops into PC over two cycles; W and flags untouched.
// - Rotate left through carry: old carry to bit 0, old bit 7 to carry.
// - Rotate destination bit 0 writes W, 1 writes back to the file register.
module return_and_rotate_exec #(
	parameter int PC_W = ret_rot_pkg::PC_W
) (
	input  wire logic                             i_sys_clk,
	input  wire logic                             i_srst,
	input  wire logic                             i_insn_valid,
	input  wire logic [ret_rot_pkg::INSN_W-1:0]  i_insn,
	input  wire logic [PC_W-1:0]                 i_stack_top,
	input  wire logic [ret_rot_pkg::WORD_W-1:0]  i_file_rdata,
	input  wire logic                             i_carry,
	input  wire logic [ret_rot_pkg::WORD_W-1:0]  i_irq_control_reg,
	output logic                                  o_busy,
	output logic                                  o_stack_pop,
	output logic                                  o_pc_load,
	output logic [PC_W-1:0]                      o_pc_value,
	output logic                                  o_w_we,
	output logic [ret_rot_pkg::WORD_W-1:0]       o_w_data,
	output logic                                  o_file_we,
	output logic [ret_rot_pkg::FADDR_W-1:0]      o_file_addr,
	output logic [ret_rot_pkg::WORD_W-1:0]       o_file_wdata,
	output logic                                  o_carry_we,
	output logic                                  o_carry,
	output logic                                  o_irq_we,
	output logic [ret_rot_pkg::WORD_W-1:0]       o_irq_control_reg
);
	// Decoded fields travel as one bundle from the decoder to the next-value logic
	ret_rot_if dif ();

	// Registered results, each beside its next value
	ret_rot_pkg::state_type state;
	ret_rot_pkg::state_type next_state;
	logic                              stack_pop;
	logic                              next_stack_pop;
	logic                              pc_load;
	logic                              next_pc_load;
	logic [PC_W-1:0]                   pc_value;
	logic [PC_W-1:0]                   next_pc_value;
	logic                              w_we;
	logic                              next_w_we;
	logic [ret_rot_pkg::WORD_W-1:0]   w_data;
	logic [ret_rot_pkg::WORD_W-1:0]   next_w_data;
	logic                              file_we;
	logic                              next_file_we;
	logic [ret_rot_pkg::FADDR_W-1:0]  file_addr;
	logic [ret_rot_pkg::FADDR_W-1:0]  next_file_addr;
	logic [ret_rot_pkg::WORD_W-1:0]   file_wdata;
	logic [ret_rot_pkg::WORD_W-1:0]   next_file_wdata;
	logic                              carry_we;
	logic                              next_carry_we;
	logic                              carry;
	logic                              next_carry;
	logic                              irq_we;
	logic                              next_irq_we;
	logic [ret_rot_pkg::WORD_W-1:0]   irq_reg;
	logic [ret_rot_pkg::WORD_W-1:0]   next_irq_reg;
	// Combinational helpers
	logic [ret_rot_pkg::WORD_W-1:0]   rotated;
	logic                              accept;

	// Decoder sees only accepted words, so a refused word decodes as no operation
	ret_rot_decode u_decode (
		.i_insn  (i_insn),
		.i_valid (accept),
		.dec     (dif.dec)
	);

	// Second cycle of a return is the flush cycle; new words are ignored then
	assign accept = i_insn_valid && (state == ret_rot_pkg::ST_IDLE);

	assign rotated = {i_file_rdata[ret_rot_pkg::MSB_BIT-1:0], i_carry};

	// Next values of the flow group: stack pop, PC load, enable write and the flush state
	always_comb begin
		next_state     = ret_rot_pkg::ST_IDLE;
		next_stack_pop = 1'b0;
		next_pc_load   = 1'b0;
		next_pc_value  = pc_value;
		next_irq_we    = 1'b0;
		next_irq_reg   = irq_reg;
		// The busy cycle decodes as no operation, so the flush state falls back to idle
		case (dif.op)
			ret_rot_pkg::OP_IRQ_RET: begin
				next_stack_pop = 1'b1;
				next_pc_load   = 1'b1;
				next_pc_value  = i_stack_top;
				next_irq_we    = 1'b1;
				// Read-modify-write keeps the other control bits as they stood
				next_irq_reg   = i_irq_control_reg;
				next_irq_reg[ret_rot_pkg::GIE_BIT] = 1'b1;
				next_state     = ret_rot_pkg::ST_FLUSH;
			end
			ret_rot_pkg::OP_LIT_RET: begin
				next_stack_pop = 1'b1;
				next_pc_load   = 1'b1;
				next_pc_value  = i_stack_top;
				next_state     = ret_rot_pkg::ST_FLUSH;
			end
			ret_rot_pkg::OP_SUB_RET: begin
				// pop only, W and flags kept
				next_stack_pop = 1'b1;
				next_pc_load   = 1'b1;
				next_pc_value  = i_stack_top;
				next_state     = ret_rot_pkg::ST_FLUSH;
			end
			default: begin
				next_state = ret_rot_pkg::ST_IDLE;
			end
		endcase
	end

	// Next values of the data group: W, file register and carry write-backs
	always_comb begin
		next_w_we       = 1'b0;
		next_w_data     = w_data;
		next_file_we    = 1'b0;
		next_file_addr  = file_addr;
		next_file_wdata = file_wdata;
		next_carry_we   = 1'b0;
		next_carry      = carry;
		// A refused or unknown word decodes as no operation and writes nothing
		case (dif.op)
			ret_rot_pkg::OP_LIT_RET: begin
				next_w_we   = 1'b1;
				next_w_data = dif.literal;
			end
			ret_rot_pkg::OP_ROT_LEFT: begin
				next_carry_we = 1'b1;
				next_carry    = i_file_rdata[ret_rot_pkg::MSB_BIT];
				if (dif.dest == ret_rot_pkg::DEST_W) begin
					next_w_we   = 1'b1;
					next_w_data = rotated;
				end else begin
					next_file_we    = 1'b1;
					next_file_addr  = dif.faddr;
					next_file_wdata = rotated;
				end
			end
			// Returns other than the literal one leave W, file and carry alone
			default: begin
				next_w_we = 1'b0;
			end
		endcase
	end

	// Flow registers; strobes clear on reset so nothing commits spuriously
	always_ff @(posedge i_sys_clk) begin
		if (i_srst) begin
			state     <= ret_rot_pkg::ST_IDLE;
			stack_pop <= 1'b0;
			pc_load   <= 1'b0;
			pc_value  <= '0;
			irq_we    <= 1'b0;
			irq_reg   <= '0;
		end else begin
			state     <= next_state;
			stack_pop <= next_stack_pop;
			pc_load   <= next_pc_load;
			pc_value  <= next_pc_value;
			irq_we    <= next_irq_we;
			irq_reg   <= next_irq_reg;
		end
	end

	// Data registers; held data means something only under its strobe
	always_ff @(posedge i_sys_clk) begin
		if (i_srst) begin
			w_we       <= 1'b0;
			w_data     <= '0;
			file_we    <= 1'b0;
			file_addr  <= '0;
			file_wdata <= '0;
			carry_we   <= 1'b0;
			carry      <= 1'b0;
		end else begin
			w_we       <= next_w_we;
			w_data     <= next_w_data;
			file_we    <= next_file_we;
			file_addr  <= next_file_addr;
			file_wdata <= next_file_wdata;
			carry_we   <= next_carry_we;
			carry      <= next_carry;
		end
	end

	// busy during the second cycle so fetch inserts a bubble
	assign o_busy            = (state == ret_rot_pkg::ST_FLUSH);
	assign o_stack_pop       = stack_pop;
	assign o_pc_load         = pc_load;
	assign o_pc_value        = pc_value;

	// Data outputs hold between strobes; consumers qualify them with the write enables
	assign o_w_we            = w_we;
	assign o_w_data          = w_data;
	assign o_file_we         = file_we;
	assign o_file_addr       = file_addr;
	assign o_file_wdata      = file_wdata;
	assign o_carry_we        = carry_we;
	assign o_carry           = carry;
	assign o_irq_we          = irq_we;
	assign o_irq_control_reg = irq_reg;
endmodule

// ===== ret_rot_exec_sva.sv
// Concurrent checks on the return and rotate execute block
`timescale 1ns/1ps
module ret_rot_exec_sva #(
	parameter int PC_W = 13
) (
	input wire logic            i_sys_clk,
	input wire logic            i_srst,
	input wire logic            i_insn_valid,
	input wire logic [13:0]     i_insn,
	input wire logic [PC_W-1:0] i_stack_top,
	input wire logic [7:0]      i_file_rdata,
	input wire logic            i_carry,
	input wire logic [7:0]      i_irq_control_reg,
	input wire logic            o_busy,
	input wire logic            o_stack_pop,
	input wire logic            o_pc_load,
	input wire logic [PC_W-1:0] o_pc_value,
	input wire logic            o_w_we,
	input wire logic [7:0]      o_w_data,
	input wire logic            o_file_we,
	input wire logic [6:0]      o_file_addr,
	input wire logic [7:0]      o_file_wdata,
	input wire logic            o_carry_we,
	input wire logic            o_carry,
	input wire logic            o_irq_we,
	input wire logic [7:0]      o_irq_control_reg
);
	default clocking cb @(posedge i_sys_clk); endclocking
	default disable iff (i_srst);
	// Word accepted this edge; busy words are refused
	logic take;
	assign take = i_insn_valid && !o_busy;
	a_pop_loads_pc: assert property (o_stack_pop |-> o_pc_load && o_pc_value == $past(i_stack_top))
		else $error("pop without matching pc load");
	a_irq_sets_enable: assert property (o_irq_we |-> o_stack_pop && !o_carry_we
		&& o_irq_control_reg == ($past(i_irq_control_reg) | 8'h80))
		else $error("interrupt enable not set");
	a_return_two_cycles: assert property (take && i_insn == 14'h0009 |=> o_busy && o_irq_we ##1 !o_busy)
		else $error("interrupt return length wrong");
	a_literal_into_w: assert property (take && i_insn[13:10] == 4'hD
		|=> o_w_we && o_w_data == $past(i_insn[7:0]))
		else $error("literal not written");
	a_literal_keeps_flags: assert property (o_w_we && o_stack_pop |-> !o_carry_we && !o_irq_we && !o_file_we)
		else $error("literal return touched flags");
	a_sub_keeps_w: assert property (take && i_insn == 14'h0008 |=> o_stack_pop && !o_w_we && !o_carry_we)
		else $error("subroutine return wrong");
	a_rotate_carry: assert property (take && i_insn[13:8] == 6'h0D
		|=> o_carry_we && o_carry == $past(i_file_rdata[7]))
		else $error("rotate carry wrong");
	a_rotate_result: assert property (take && i_insn[13:8] == 6'h0D
		|=> (o_file_we ? o_file_wdata : o_w_data) == {$past(i_file_rdata[6:0]), $past(i_carry)})
		else $error("rotate result wrong");
	a_rotate_dest: assert property (take && i_insn[13:8] == 6'h0D
		|=> o_file_we == $past(i_insn[7]) && o_w_we != o_file_we)
		else $error("rotate destination wrong");
	a_rotate_addr: assert property (take && i_insn[13:7] == 7'h1B
		|=> o_file_addr == $past(i_insn[6:0]))
		else $error("rotate write-back address wrong");
	a_single_pop: assert property (o_stack_pop |=> !o_stack_pop)
		else $error("stack popped twice");
endmodule
bind return_and_rotate_exec ret_rot_exec_sva #(.PC_W(PC_W)) chk_u (
	.i_sys_clk         (i_sys_clk),
	.i_srst            (i_srst),
	.i_insn_valid      (i_insn_valid),
	.i_insn            (i_insn),
	.i_stack_top       (i_stack_top),
	.i_file_rdata      (i_file_rdata),
	.i_carry           (i_carry),
	.i_irq_control_reg (i_irq_control_reg),
	.o_busy            (o_busy),
	.o_stack_pop       (o_stack_pop),
	.o_pc_load         (o_pc_load),
	.o_pc_value        (o_pc_value),
	.o_w_we            (o_w_we),
	.o_w_data          (o_w_data),
	.o_file_we         (o_file_we),
	.o_file_addr       (o_file_addr),
	.o_file_wdata      (o_file_wdata),
	.o_carry_we        (o_carry_we),
	.o_carry           (o_carry),
	.o_irq_we          (o_irq_we),
	.o_irq_control_reg (o_irq_control_reg)
);

// ===== tb.sv
// Self-checking bench for the return and rotate execute block
`timescale 1ns/1ps
`define CHK(nm, ex, got) begin checks_done++; if ((got) !== (ex)) begin err_count++; \
	$display("[FAIL] %s expected %h seen %h", nm, ex, got); end end
module tb;
	localparam int PW = ret_rot_pkg::PC_W;
	typedef logic [PW+38:0] result_type;
	logic            i_sys_clk = 1'b0;
	logic            i_srst = 1'b1;
	logic            i_insn_valid = 1'b0;
	logic [13:0]     i_insn = 14'h0000;
	logic [PW-1:0]   i_stack_top = '0;
	logic [7:0]      i_file_rdata = 8'h00;
	logic            i_carry = 1'b0;
	logic [7:0]      i_irq_control_reg = 8'h00;
	logic            o_busy, o_stack_pop, o_pc_load, o_w_we, o_file_we, o_carry_we, o_carry, o_irq_we;
	logic [PW-1:0]   o_pc_value;
	logic [7:0]      o_w_data, o_file_wdata, o_irq_control_reg;
	logic [6:0]      o_file_addr;
	result_type      note_q[$];
	result_type      seen, exp_r;
	int              err_count = 0;
	int              checks_done = 0;
	int              cyc = 0;
	return_and_rotate_exec dut_u (
		.i_sys_clk         (i_sys_clk),
		.i_srst            (i_srst),
		.i_insn_valid      (i_insn_valid),
		.i_insn            (i_insn),
		.i_stack_top       (i_stack_top),
		.i_file_rdata      (i_file_rdata),
		.i_carry           (i_carry),
		.i_irq_control_reg (i_irq_control_reg),
		.o_busy            (o_busy),
		.o_stack_pop       (o_stack_pop),
		.o_pc_load         (o_pc_load),
		.o_pc_value        (o_pc_value),
		.o_w_we            (o_w_we),
		.o_w_data          (o_w_data),
		.o_file_we         (o_file_we),
		.o_file_addr       (o_file_addr),
		.o_file_wdata      (o_file_wdata),
		.o_carry_we        (o_carry_we),
		.o_carry           (o_carry),
		.o_irq_we          (o_irq_we),
		.o_irq_control_reg (o_irq_control_reg)
	);
	always #12.5 i_sys_clk = ~i_sys_clk;
	// Data fields masked by their strobes, since held data is stale
	assign seen = {o_busy, o_stack_pop, o_pc_load, o_pc_load ? o_pc_value : {PW{1'b0}}, o_w_we,
		o_w_we ? o_w_data : 8'h00, o_file_we, o_file_we ? o_file_addr : 7'h00, o_file_we ? o_file_wdata : 8'h00,
		o_carry_we, o_carry_we & o_carry, o_irq_we, o_irq_we ? o_irq_control_reg : 8'h00};
	// Expected result of one accepted word
	function automatic result_type expect_of(logic [13:0] w, logic [PW-1:0] top, logic [7:0] rd, logic c,
		logic [7:0] irq);
		logic       ret;
		logic [7:0] rot;
		ret = (w == 14'h0009) || (w == 14'h0008) || (w[13:10] == 4'hD);
		rot = {rd[6:0], c};
		if (w[13:8] == 6'h0D)
			return {3'h0, {PW{1'b0}}, !w[7], w[7] ? 8'h00 : rot, w[7], w[7] ? w[6:0] : 7'h00,
				w[7] ? rot : 8'h00, 1'b1, rd[7], 9'h000};
		return {{3{ret}}, ret ? top : {PW{1'b0}}, w[13:10] == 4'hD, w[13:10] == 4'hD ? w[7:0] : 8'h00,
			18'h00000, w == 14'h0009, w == 14'h0009 ? (irq | 8'h80) : 8'h00};
	endfunction
	// Drive one word; a return also gets a refused word in its busy cycle
	task automatic issue(logic [13:0] w);
		result_type e;
		@(negedge i_sys_clk);
		i_insn_valid = 1'b1;
		i_insn = w;
		i_stack_top = PW'($urandom);
		i_file_rdata = 8'($urandom);
		i_carry = 1'($urandom);
		i_irq_control_reg = 8'($urandom);
		e = expect_of(w, i_stack_top, i_file_rdata, i_carry, i_irq_control_reg);
		if (e !== '0)
			note_q.push_back(e);
		if (e[PW+38]) begin
			@(negedge i_sys_clk);
			i_insn = {6'h0D, 8'($urandom)};
		end
	endtask
	task automatic wrap_up();
		$display("checks %0d errors %0d", checks_done, err_count);
		if (err_count == 0 && checks_done > 0)
			$display("Regression OK");
		else
			$display("Regression broken");
		$finish;
	endtask
	// Any strobe consumes the oldest note; all-ones marks a missing note
	always @(posedge i_sys_clk) begin
		#1;
		if (seen !== '0) begin
			exp_r = (note_q.size() != 0) ? note_q.pop_front() : '1;
			`CHK("result", exp_r, seen)
		end
	end
	// Hang guard, well above 305 words of at most two cycles
	always @(posedge i_sys_clk) begin
		cyc++;
		if (cyc == 4000) begin
			err_count++;
			wrap_up();
		end
	end
	initial begin
		logic [31:0] r;
		void'($urandom(32'hC075));
		repeat (4) @(negedge i_sys_clk);
		i_srst = 1'b0;
		// Literal bounds, top file address both ways, then an unknown word
		issue(14'h3400);
		issue(14'h37FF);
		issue(14'h0DFF);
		issue(14'h0D7F);
		issue(14'h0000);
		for (int k = 0; k < 300; k++) begin
			r = $urandom;
			case (r[1:0])
				2'h0: issue(14'h0009);
				2'h1: issue(14'h0008);
				2'h2: issue({4'hD, r[11:2]});
				default: issue({6'h0D, r[9:2]});
			endcase
		end
		@(negedge i_sys_clk);
		i_insn_valid = 1'b0;
		repeat (3) @(negedge i_sys_clk);
		`CHK("pending notes", 0, note_q.size())
		wrap_up();
	end
endmodule
